// *** dcid_top.sv ***
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dcid_consts.svh"
// How it works
// RULE1: straps caught after power-up reset select the initial segment pattern.
// RULE2: unstrapped display test reads one, lamp test zero: all lit.
// RULE3: test patterns one or two sound the beeper without a command.
// RULE4: internal reset held for the power-up interval, then released.
// RULE5: ready-to-receive line goes low once reset ends.
// RULE6: host toggles serial data and clock; commands arrive only then.
// RULE7: timing scaled from the 4.19 MHz reference cycle; the code scales its counts from the 100 MHz core clock instead.
// RULE8: eleven grids scanned 0 to 10, one enabled at a time.
// RULE9: a segment lights only when anode and grid are both driven.
// RULE10: watchdog reset, suppressed while its disable strap is grounded.
// RULE11: pattern keeps refreshing until serial writes replace memory.
module dcid_top #(
  parameter int POR_CYC = `DCID_POR_US * `DCID_CLK_MHZ,
  parameter int WDOG_CYC = `DCID_WDOG_US * `DCID_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic display_test_strap_n,
  input wire logic lamp_test_strap_n,
  input wire logic watchdog_disable_n,
  input wire logic host_serial_command_clock,
  input wire logic host_serial_command_data,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic host_link_ready_n,
  output logic ctrl_reset,
  output logic beeper,
  output logic [10:0] grid_drive,
  output logic [15:0] anode_drive
);
  logic [1:0] rs_r;
  logic rst_core_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rs_r <= 2'b00;
    else rs_r <= {rs_r[0], 1'b1};
  end
  assign rst_core_n = rs_r[1];

  logic dt_s, lt_s, wd_s, sck_s, sda_s;
  dcid_sync2 u_dt (.core_clk(core_clk), .rst_n(rst_core_n), .d(display_test_strap_n), .q(dt_s));
  dcid_sync2 u_lt (.core_clk(core_clk), .rst_n(rst_core_n), .d(lamp_test_strap_n), .q(lt_s));
  dcid_sync2 u_wd (.core_clk(core_clk), .rst_n(rst_core_n), .d(watchdog_disable_n), .q(wd_s));
  dcid_sync2 u_ck (.core_clk(core_clk), .rst_n(rst_core_n),
    .d(host_serial_command_clock), .q(sck_s));
  dcid_sync2 u_da (.core_clk(core_clk), .rst_n(rst_core_n),
    .d(host_serial_command_data), .q(sda_s));

  // power-up and watchdog reset sequencing
  logic [31:0] por_r, por_nxt, wd_r, wd_nxt;
  logic in_rst_r, in_rst_nxt, kick_r, kick_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic wdog_fire;
  assign wdog_fire = wd_s && (wd_r >= 32'(WDOG_CYC - 1)); // [RULE10]
  always_comb begin
    por_nxt = por_r;
    in_rst_nxt = in_rst_r;
    wd_nxt = wd_r + 32'h1;
    if (in_rst_r) begin
      wd_nxt = 32'h0;
      if (por_r >= 32'(POR_CYC - 1)) in_rst_nxt = 1'b0; // [RULE4] [RULE7]
      else por_nxt = por_r + 32'h1;
    end else if (kick_r || !wd_s) begin
      wd_nxt = 32'h0;
    end else if (wdog_fire) begin
      in_rst_nxt = 1'b1; // [RULE10]
      por_nxt = 32'h0;
    end
  end
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      por_r <= 32'h0;
      in_rst_r <= 1'b1;
      wd_r <= 32'h0;
    end else begin
      por_r <= por_nxt;
      in_rst_r <= in_rst_nxt;
      wd_r <= wd_nxt;
    end
  end
  assign ctrl_reset = in_rst_r;
  assign host_link_ready_n = in_rst_r; // [RULE5]

  // strap capture, pattern select
  dcid_pkg::dcid_pat_t pat_r, pat_nxt;
  logic beep_en_r, beep_en_nxt, rst_d_r;
  always_comb begin
    pat_nxt = pat_r;
    beep_en_nxt = beep_en_r;
    if (rst_d_r && !in_rst_r) begin
      unique case ({dt_s, lt_s}) // [RULE1] [RULE2]
        2'b11: pat_nxt = dcid_pkg::DCID_PAT_OFF;
        2'b10: pat_nxt = dcid_pkg::DCID_PAT_ON;
        2'b01: pat_nxt = dcid_pkg::DCID_PAT_ONE;
        2'b00: pat_nxt = dcid_pkg::DCID_PAT_TWO;
      endcase
      beep_en_nxt = !dt_s; // [RULE3]
    end
  end

  // serial receive: 20-bit frame, 4-bit grid address then 16 segments
  logic sck_d_r;
  logic [19:0] sh_r, sh_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [15:0] mem_r [0:10];
  logic wr_en;
  logic [3:0] wr_addr;
  always_comb begin
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    wr_en = 1'b0;
    wr_addr = sh_r[`DCID_ADDR_HI-1:`DCID_ADDR_LO-1];
    if (!in_rst_r && sck_s && !sck_d_r) begin // [RULE6]
      sh_nxt = {sh_r[18:0], sda_s};
      if (cnt_r == 5'(`DCID_FRAME_BITS - 1)) begin
        cnt_nxt = 5'h0;
        wr_en = (wr_addr < 4'(`DCID_NUM_GRIDS));
      end else begin
        cnt_nxt = cnt_r + 5'h1;
      end
    end
  end
  function automatic logic [15:0] pat_word(input dcid_pkg::dcid_pat_t p, input int i);
    unique case (p)
      dcid_pkg::DCID_PAT_OFF: pat_word = `DCID_SEG_OFF;
      dcid_pkg::DCID_PAT_ON: pat_word = `DCID_SEG_ON;
      dcid_pkg::DCID_PAT_ONE: pat_word = (i % 2 == 0) ? `DCID_PAT1 : `DCID_PAT2;
      dcid_pkg::DCID_PAT_TWO: pat_word = (i % 2 == 0) ? `DCID_PAT2 : `DCID_PAT1;
    endcase
  endfunction
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      pat_r <= dcid_pkg::DCID_PAT_ON;
      beep_en_r <= 1'b0;
      rst_d_r <= 1'b1;
      sck_d_r <= 1'b0;
      sh_r <= 20'h0;
      cnt_r <= 5'h0;
    end else begin
      pat_r <= pat_nxt;
      beep_en_r <= beep_en_nxt;
      rst_d_r <= in_rst_r;
      sck_d_r <= sck_s;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < `DCID_NUM_GRIDS; i++) begin
      if (rst_d_r && !in_rst_r) mem_r[i] <= pat_word(pat_nxt, i); // [RULE1] [RULE11]
      else if (wr_en && wr_addr == 4'(i)) mem_r[i] <= sh_nxt[15:0]; // [RULE11]
    end
  end

  // grid scan
  logic [15:0] scan_r, scan_nxt;
  logic [3:0] gidx_r, gidx_nxt;
  logic [19:0] bdiv_r, bdiv_nxt;
  logic btone_r, btone_nxt;
  dcid_pkg::dcid_drive_t drv_r, drv_nxt;
  always_comb begin
    scan_nxt = scan_r + 16'h1;
    gidx_nxt = gidx_r;
    if (scan_r == `DCID_SCAN_DIV) begin
      scan_nxt = 16'h0;
      gidx_nxt = (gidx_r == 4'(`DCID_NUM_GRIDS - 1)) ? 4'h0 : gidx_r + 4'h1; // [RULE8]
    end
    drv_nxt.grid = 11'h0;
    drv_nxt.anode = 16'h0;
    if (!in_rst_r) begin
      drv_nxt.grid = 11'(11'h1 << gidx_r); // [RULE8]
      drv_nxt.anode = mem_r[gidx_r]; // [RULE9] [RULE11]
    end
    bdiv_nxt = bdiv_r + 20'h1;
    btone_nxt = btone_r;
    if (bdiv_r == `DCID_BEEP_DIV) begin
      bdiv_nxt = 20'h0;
      btone_nxt = !btone_r;
    end
  end
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      scan_r <= 16'h0;
      gidx_r <= 4'h0;
      drv_r <= '0;
      bdiv_r <= 20'h0;
      // tone opens on its high half so a test pattern is heard at once
      btone_r <= 1'b1;
    end else begin
      scan_r <= scan_nxt;
      gidx_r <= gidx_nxt;
      drv_r <= drv_nxt;
      bdiv_r <= bdiv_nxt;
      btone_r <= btone_nxt;
    end
  end
  assign grid_drive = drv_r.grid;
  assign anode_drive = drv_r.anode;
  assign beeper = beep_en_r && btone_r && !in_rst_r && !ctrl_r[1]; // [RULE3]

  // apb: ctrl bit0 kicks watchdog (self clearing), bit1 mutes beeper
  logic [31:0] rd_nxt, prdata_r;
  logic apb_wr, apb_rd, bad;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign bad = (paddr != `DCID_REG_CTRL) && (paddr != `DCID_REG_STAT);
  always_comb begin
    ctrl_nxt = {ctrl_r[31:1], 1'b0};
    kick_nxt = 1'b0;
    rd_nxt = prdata_r;
    if (apb_wr && paddr == `DCID_REG_CTRL) begin
      ctrl_nxt = {30'h0, pwdata[1], 1'b0};
      kick_nxt = pwdata[0];
    end
    if (apb_rd) begin
      rd_nxt = 32'h0;
      if (paddr == `DCID_REG_CTRL) rd_nxt = ctrl_r;
      if (paddr == `DCID_REG_STAT) rd_nxt = {24'h0, pat_r, beep_en_r, host_link_ready_n, gidx_r};
    end
  end
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      ctrl_r <= 32'h0;
      kick_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      kick_r <= kick_nxt;
      prdata_r <= rd_nxt;
    end
  end
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && bad;

  chk_link_ready: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    $fell(in_rst_r) |-> !host_link_ready_n) else $error("ready not low after reset"); // [RULE5]
  chk_grid_onehot: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    !in_rst_r |=> $onehot(grid_drive)) else $error("grid not one-hot"); // [RULE8]
  chk_beep_test: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    beeper |-> (pat_r == dcid_pkg::DCID_PAT_ONE || pat_r == dcid_pkg::DCID_PAT_TWO))
    else $error("beep without test pattern"); // [RULE3]
  chk_strap_pat: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    (rst_d_r && !in_rst_r && dt_s && !lt_s) |=> pat_r == dcid_pkg::DCID_PAT_ON)
    else $error("default pattern wrong"); // [RULE2]
  chk_strap_off: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    (rst_d_r && !in_rst_r && dt_s && lt_s) |=> ##1 mem_r[0] == `DCID_SEG_OFF)
    else $error("off pattern wrong"); // [RULE1]
  chk_wdog_off: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    (!wd_s && !in_rst_r) |=> !in_rst_r) else $error("watchdog fired while disabled"); // [RULE10]
  chk_rst_hold: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    (in_rst_r && por_r < 32'(POR_CYC - 1)) |=> in_rst_r) else $error("reset ended early"); // [RULE4]
  chk_anode_blank: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    in_rst_r |=> (grid_drive == 11'h0 && anode_drive == 16'h0))
    else $error("drive during reset"); // [RULE9]
  cov_pat_two: cover property (@(posedge core_clk) pat_r == dcid_pkg::DCID_PAT_TWO);
  cov_frame: cover property (@(posedge core_clk) wr_en);
  cov_wdog: cover property (@(posedge core_clk) wdog_fire);
endmodule
`default_nettype wire

// *** dcid_consts.svh ***
`ifndef DCID_CONSTS_SVH
`define DCID_CONSTS_SVH
`define DCID_NUM_GRIDS 11
`define DCID_SEG_BITS 16
`define DCID_GRID_W 4
`define DCID_CLK_MHZ 100
`define DCID_REF_KHZ 4190
`define DCID_POR_US 1000
`define DCID_WDOG_US 100000
`define DCID_BEEP_DIV 20'h0C350
`define DCID_SCAN_DIV 16'h2710
`define DCID_PAT1 16'h5A5A
`define DCID_PAT2 16'hA5A5
`define DCID_SEG_OFF 16'h0000
`define DCID_SEG_ON 16'hFFFF
`define DCID_FRAME_BITS 20
`define DCID_ADDR_HI 19
`define DCID_ADDR_LO 16
`define DCID_REG_CTRL 12'h000
`define DCID_REG_STAT 12'h004
`endif

// *** dcid_pkg.sv ***
package dcid_pkg;
  typedef enum logic [1:0] {
    DCID_PAT_OFF,
    DCID_PAT_ON,
    DCID_PAT_ONE,
    DCID_PAT_TWO
  } dcid_pat_t;
  typedef struct packed {
    logic [10:0] grid;
    logic [15:0] anode;
  } dcid_drive_t;
endpackage

// *** dcid_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcid_sync2 (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic s1_r;
  logic s2_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule
`default_nettype wire

// *** dcid_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcid_host_model (
  output logic host_serial_command_clock,
  output logic host_serial_command_data
);
  initial begin
    host_serial_command_clock = 1'h0;
    host_serial_command_data = 1'h0;
  end
  // msb first; clock parked low between frames
  task automatic send(input logic [19:0] frame, input realtime half);
    // step off the core clock edge before the first data change
    #1;
    for (int i = 19; i >= 0; i--) begin
      host_serial_command_data = frame[i];
      #(half) host_serial_command_clock = 1'h1;
      #(half) host_serial_command_clock = 1'h0;
    end
    host_serial_command_data = ~frame[0];
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dcid_consts.svh"
module tb_top;
  typedef struct {logic d; logic l; logic [1:0] pat; logic [15:0] an;} dcid_row_t;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic display_test_strap_n = 1'h1;
  logic lamp_test_strap_n = 1'h0;
  logic watchdog_disable_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, host_link_ready_n, ctrl_reset, beeper, err;
  logic host_serial_command_clock, host_serial_command_data;
  logic [10:0] grid_drive;
  logic [15:0] anode_drive;
  int miscompares = 0;
  int total_checks = 0;
  int n;
  dcid_row_t rows[4] = '{'{1'h1, 1'h1, 2'h0, 16'h0000}, '{1'h1, 1'h0, 2'h1, 16'hFFFF},
    '{1'h0, 1'h1, 2'h2, `DCID_PAT1}, '{1'h0, 1'h0, 2'h3, `DCID_PAT2}};
  always #5 core_clk = ~core_clk;
  dcid_top #(.POR_CYC(20), .WDOG_CYC(200)) i_dut (
    .core_clk, .rst_n, .display_test_strap_n, .lamp_test_strap_n, .watchdog_disable_n,
    .host_serial_command_clock, .host_serial_command_data, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .host_link_ready_n, .ctrl_reset,
    .beeper, .grid_drive, .anode_drive);
  dcid_host_model i_host (.host_serial_command_clock, .host_serial_command_data);
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (k >= 50) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic do_reset(input logic d, input logic l);
    int k = 4;
    @(posedge core_clk);
    rst_n <= 1'h0;
    display_test_strap_n <= d;
    lamp_test_strap_n <= l;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge core_clk);
    cmp("por_active", 1, ctrl_reset);
    cmp("ready_n_held", 1, host_link_ready_n);
    while (ctrl_reset === 1'h1 && k < 100) begin
      @(posedge core_clk);
      k++;
    end
    cmp("por_length", 1, k >= 18 && k <= 26);
    repeat (3) @(posedge core_clk);
    cmp("ready_n_low", 0, host_link_ready_n);
  endtask
  task automatic wait_grid(input int g);
    int k = 0;
    while (grid_drive !== 11'h1 << g && k < 25000) begin
      @(posedge core_clk);
      k++;
    end
    repeat (3) @(posedge core_clk);
    cmp("grid_scan", 11'h1 << g, grid_drive);
  endtask
  initial begin
    for (int i = 0; i < 4; i++) begin
      do_reset(rows[i].d, rows[i].l);
      apb(1'h0, `DCID_REG_STAT, 32'h0);
      cmp("pattern", rows[i].pat, rd[7:6]);
      cmp("beep_enable", rows[i].pat[1], rd[5]);
      cmp("grid_onehot", 11'h1 << rd[3:0], grid_drive);
      cmp("anode", rows[i].an, anode_drive);
      if (rows[i].pat[1]) begin
        cmp("beeper_on", 1, beeper);
        apb(1'h1, `DCID_REG_CTRL, 32'h2);
        @(posedge core_clk);
        cmp("beeper_muted", 0, beeper);
      end else begin
        cmp("beeper_quiet", 0, beeper);
      end
    end
    do_reset(1'h1, 1'h0);
    apb(1'h0, `DCID_REG_STAT, 32'h0);
    n = (rd[3:0] + 2) % 11;
    i_host.send({n[3:0], 16'h1234}, 62.5);
    wait_grid(n);
    cmp("anode_written", 16'h1234, anode_drive);
    wait_grid((n + 1) % 11);
    cmp("anode_kept", 16'hFFFF, anode_drive);
    cmp("wdog_suppressed", 0, ctrl_reset);
    apb(1'h0, 12'h008, 32'h0);
    cmp("unmapped_err", 1, err);
    cmp("unmapped_data", 0, rd);
    watchdog_disable_n <= 1'h1;
    repeat (5) begin
      apb(1'h1, `DCID_REG_CTRL, 32'h1);
      repeat (120) @(posedge core_clk);
      cmp("wdog_kicked", 0, ctrl_reset);
    end
    n = 0;
    while (ctrl_reset !== 1'h1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    cmp("wdog_fired", 1, ctrl_reset);
    watchdog_disable_n <= 1'h0;
    stop_test();
  end
  initial begin
    #1000000;
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
